// ===== logic/laser_seq_params.svh
`ifndef LASER_SEQ_PARAMS_SVH
`define LASER_SEQ_PARAMS_SVH
`define CLK_HZ             32'd10_000_000
`define FREQ_MIN_HZ        32'd20_000
`define FREQ_MAX_HZ        32'd80_000
`define REG_CTRL           12'h000
`define REG_FREQ           12'h004
`define REG_PRE            12'h008
`define REG_POST           12'h00c
`define REG_CYCLE          12'h010
`define REG_POWER          12'h014
`define REG_STATUS         12'h018
`define CTRL_BEAM_BIT      0
`define CTRL_FIBER_BIT     1
`define CTRL_SCAN_BIT      2
`define CTRL_RESET         32'h0000_0002
`define FREQ_RESET         32'h0000_4e20
`define PRE_RESET          32'h0000_0064
`define POST_RESET         32'h0000_0064
`define CYCLE_RESET        32'h0000_0064
`endif

// ===== logic/laser_seq_pkg.sv
package laser_seq_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PRE,
    ST_GATE,
    ST_POST,
    ST_CYCLE
  } seq_state_t;
  typedef enum logic [1:0] {
    PW_IDLE,
    PW_SETUP,
    PW_STROBE,
    PW_HOLD
  } power_state_t;
endpackage

// ===== logic/fiber_laser_gate_sequencer.sv
`timescale 1ns/1ns
`include "laser_seq_params.svh"
// What this block does
// RULE1: with fiber signalling on, clamp modulation frequency into 20 to 80 kHz.
// RULE2: on beam request raise pre-amp enable, wait Pre delay, then open gate.
// RULE3: after gate closes keep pre-amp enable at most Post delay, then drop.
// RULE4: gate reopening during Post abandons the count; restart on next close.
// RULE5: after pre-amp enable drops, wait Cycle delay before raising it again.
// RULE6: power is an 8-bit parallel word with separate latch strobe.
// RULE7: gate on output bit 0, inverted gate on output bit 2; bit 0 carries the power latch instead in scan-card mode.
// RULE8: pre-amp enable on extended bit 5, or general bit 1 in scan-card mode.
// RULE9: power latch on extended bit 4, or general bit 0 in scan-card mode.
// RULE10: eight power bits on dedicated outputs, lowest bit first.
// RULE11: modulation output is a free-running clock independent of gate timing.
// RULE12: power word stable one clock before strobe, and until strobe ends.
module fiber_laser_gate_sequencer #(
  parameter int CNT_W = 32
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [7:0]       gen_out,
  output logic [7:0]       ext_out,
  output logic             scan_card_beam_on_out,
  output logic             scan_card_modulation_out,
  output logic [7:0]       scan_card_power_bits
);

  logic [31:0]              ctrl_q;
  logic [31:0]              freq_q;
  logic [CNT_W-1:0]         pre_q;
  logic [CNT_W-1:0]         post_q;
  logic [CNT_W-1:0]         cycle_q;
  logic [7:0]               power_q;
  logic [7:0]               power_out_q;
  logic                     strobe_q;
  logic                     power_pend_q;
  logic                     aw_held_q;
  logic                     w_held_q;
  logic [11:0]              awaddr_q;
  logic [31:0]              wdata_q;
  logic [3:0]               wstrb_q;
  logic                     bvalid_q;
  logic                     bad_w_q;
  logic                     rvalid_q;
  logic [31:0]              rdata_q;
  logic                     bad_r_q;
  laser_seq_pkg::seq_state_t   st_q;
  laser_seq_pkg::seq_state_t   st_d;
  laser_seq_pkg::power_state_t pw_q;
  logic [CNT_W-1:0]         cnt_q;
  logic [CNT_W-1:0]         cnt_d;
  logic [31:0]              mod_cnt_q;
  logic [31:0]              half_q;
  logic                     mod_q;
  logic                     enable_q;
  logic                     gate_q;

  // axi write path
  wire        wr_fire   = aw_held_q && w_held_q && !bvalid_q;
  wire [11:0] wr_addr   = awaddr_q;
  wire        wr_ctrl   = wr_fire && (wr_addr == `REG_CTRL);
  wire        wr_freq   = wr_fire && (wr_addr == `REG_FREQ);
  wire        wr_pre    = wr_fire && (wr_addr == `REG_PRE);
  wire        wr_post   = wr_fire && (wr_addr == `REG_POST);
  wire        wr_cycle  = wr_fire && (wr_addr == `REG_CYCLE);
  wire        wr_power  = wr_fire && (wr_addr == `REG_POWER);
  wire        wr_known  = (wr_addr == `REG_CTRL) || (wr_addr == `REG_FREQ) || (wr_addr == `REG_PRE) ||
                          (wr_addr == `REG_POST) || (wr_addr == `REG_CYCLE) || (wr_addr == `REG_POWER) ||
                          (wr_addr == `REG_STATUS);
  wire [31:0] wmask     = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire [31:0] pre_ext   = 32'(pre_q);
  wire [31:0] post_ext  = 32'(post_q);
  wire [31:0] cycle_ext = 32'(cycle_q);

  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready  = !w_held_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bad_w_q ? 2'b10 : 2'b00;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = bad_r_q ? 2'b10 : 2'b00;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 12'h000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bad_w_q   <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        bvalid_q  <= 1'b1;
        bad_w_q   <= !wr_known || (wr_addr[1:0] != 2'b00);
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // configuration registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_q  <= `CTRL_RESET;
      freq_q  <= `FREQ_RESET;
      pre_q   <= CNT_W'(`PRE_RESET);
      post_q  <= CNT_W'(`POST_RESET);
      cycle_q <= CNT_W'(`CYCLE_RESET);
      power_q <= 8'h00;
    end else begin
      if (wr_ctrl)
        ctrl_q <= (ctrl_q & ~wmask) | (wdata_q & wmask & 32'h0000_0007);
      if (wr_freq)
        freq_q <= (freq_q & ~wmask) | (wdata_q & wmask);
      if (wr_pre)
        pre_q <= CNT_W'((pre_ext & ~wmask) | (wdata_q & wmask));
      if (wr_post)
        post_q <= CNT_W'((post_ext & ~wmask) | (wdata_q & wmask));
      if (wr_cycle)
        cycle_q <= CNT_W'((cycle_ext & ~wmask) | (wdata_q & wmask));
      if (wr_power && wstrb_q[0])
        power_q <= wdata_q[7:0];
    end
  end

  // axi read path
  wire [31:0] status_word = {24'h00_0000, power_pend_q, strobe_q, 1'b0, st_q, enable_q, gate_q};
  wire        rd_known = (s_axi_araddr == `REG_CTRL) || (s_axi_araddr == `REG_FREQ) ||
                         (s_axi_araddr == `REG_PRE) || (s_axi_araddr == `REG_POST) ||
                         (s_axi_araddr == `REG_CYCLE) || (s_axi_araddr == `REG_POWER) ||
                         (s_axi_araddr == `REG_STATUS);
  wire [31:0] rd_mux =
    (s_axi_araddr == `REG_CTRL)   ? ctrl_q :
    (s_axi_araddr == `REG_FREQ)   ? freq_q :
    (s_axi_araddr == `REG_PRE)    ? pre_ext :
    (s_axi_araddr == `REG_POST)   ? post_ext :
    (s_axi_araddr == `REG_CYCLE)  ? cycle_ext :
    (s_axi_araddr == `REG_POWER)  ? {24'h00_0000, power_q} :
    (s_axi_araddr == `REG_STATUS) ? status_word : 32'h0000_0000;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      bad_r_q  <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      bad_r_q  <= !rd_known;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // modulation clock
  wire        fiber_on = ctrl_q[`CTRL_FIBER_BIT];
  wire        scan_on  = ctrl_q[`CTRL_SCAN_BIT];
  wire        beam_req = ctrl_q[`CTRL_BEAM_BIT];
  // RULE1: band clamp
  wire [31:0] freq_lo  = (freq_q < `FREQ_MIN_HZ) ? `FREQ_MIN_HZ : freq_q;
  wire [31:0] freq_cl  = (freq_lo > `FREQ_MAX_HZ) ? `FREQ_MAX_HZ : freq_lo;
  wire [31:0] freq_use = fiber_on ? freq_cl : ((freq_q == 32'h0000_0000) ? 32'h0000_0001 : freq_q);
  wire [31:0] half_raw = (`CLK_HZ >> 1) / freq_use;
  wire [31:0] half_per = (half_raw == 32'h0000_0000) ? 32'h0000_0001 : half_raw;

  // divide registered, kept off the toggle counter path
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      half_q <= (`CLK_HZ >> 1) / `FREQ_RESET;
    end else begin
      half_q <= half_per;
    end
  end

  // RULE11: free-running toggle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mod_cnt_q <= 32'h0000_0000;
      mod_q     <= 1'b0;
    end else if (mod_cnt_q + 32'h0000_0001 >= half_q) begin
      mod_cnt_q <= 32'h0000_0000;
      mod_q     <= !mod_q;
    end else begin
      mod_cnt_q <= mod_cnt_q + 32'h0000_0001;
    end
  end

  // gate sequencer
  wire cnt_done = (cnt_q == '0);
  wire [CNT_W-1:0] cnt_dec = cnt_q - CNT_W'(1);

  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_done ? cnt_q : cnt_dec;
    unique case (st_q)
      laser_seq_pkg::ST_IDLE: begin
        // RULE2: enable first
        if (beam_req) begin
          st_d  = laser_seq_pkg::ST_PRE;
          cnt_d = pre_q;
        end
      end
      laser_seq_pkg::ST_PRE: begin
        // RULE2: gate after pre
        if (!beam_req) begin
          st_d  = laser_seq_pkg::ST_POST;
          cnt_d = post_q;
        end else if (cnt_done || cnt_q == CNT_W'(1)) begin
          st_d = laser_seq_pkg::ST_GATE;
        end
      end
      laser_seq_pkg::ST_GATE: begin
        // RULE3: start post
        if (!beam_req) begin
          st_d  = laser_seq_pkg::ST_POST;
          cnt_d = post_q;
        end
      end
      laser_seq_pkg::ST_POST: begin
        // RULE4: abandon post
        if (beam_req) begin
          st_d = laser_seq_pkg::ST_GATE;
        end else if (cnt_done || cnt_q == CNT_W'(1)) begin
          // RULE5: cycle lockout
          st_d  = laser_seq_pkg::ST_CYCLE;
          cnt_d = cycle_q;
        end
      end
      laser_seq_pkg::ST_CYCLE: begin
        // RULE5: wait cycle
        if (cnt_done || cnt_q == CNT_W'(1))
          st_d = laser_seq_pkg::ST_IDLE;
      end
      default: begin
        st_d  = laser_seq_pkg::ST_IDLE;
        cnt_d = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q     <= laser_seq_pkg::ST_IDLE;
      cnt_q    <= '0;
      enable_q <= 1'b0;
      gate_q   <= 1'b0;
    end else begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      enable_q <= (st_d == laser_seq_pkg::ST_PRE) || (st_d == laser_seq_pkg::ST_GATE) ||
                  (st_d == laser_seq_pkg::ST_POST);
      gate_q   <= (st_d == laser_seq_pkg::ST_GATE);
    end
  end

  // RULE6: word then latch strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pw_q         <= laser_seq_pkg::PW_IDLE;
      power_out_q  <= 8'h00;
      strobe_q     <= 1'b0;
      power_pend_q <= 1'b0;
    end else begin
      if (wr_power && wstrb_q[0])
        power_pend_q <= 1'b1;
      unique case (pw_q)
        laser_seq_pkg::PW_IDLE: begin
          if (power_pend_q) begin
            power_out_q  <= power_q;
            power_pend_q <= wr_power && wstrb_q[0];
            pw_q         <= laser_seq_pkg::PW_SETUP;
          end
        end
        // RULE12: setup before strobe
        laser_seq_pkg::PW_SETUP: begin
          strobe_q <= 1'b1;
          pw_q     <= laser_seq_pkg::PW_STROBE;
        end
        laser_seq_pkg::PW_STROBE: begin
          strobe_q <= 1'b0;
          pw_q     <= laser_seq_pkg::PW_HOLD;
        end
        // RULE12: hold after strobe
        laser_seq_pkg::PW_HOLD: begin
          pw_q <= laser_seq_pkg::PW_IDLE;
        end
      endcase
    end
  end

  // pin mapping
  always_comb begin
    gen_out = 8'h00;
    ext_out = 8'h00;
    // RULE7: gate true (power latch in scan-card mode) and inverted
    gen_out[0] = scan_on ? strobe_q : gate_q;
    gen_out[2] = !gate_q;
    // RULE8: enable placement
    if (scan_on)
      gen_out[1] = enable_q;
    else
      ext_out[5] = enable_q;
    // RULE9: latch placement
    if (!scan_on)
      ext_out[4] = strobe_q;
  end

  assign scan_card_beam_on_out    = gate_q;
  assign scan_card_modulation_out = mod_q;
  // RULE10: dedicated power bits
  assign scan_card_power_bits     = power_out_q;

endmodule

// ===== verif/laser_port_model.sv
`timescale 1ns/1ns
module laser_port_model (
  input  wire logic       clk_sys,
  input  wire logic       strobe,
  input  wire logic [7:0] power,
  output logic      [7:0] power_q
);
  logic strobe_q;
  always @(posedge clk_sys) begin
    strobe_q <= strobe;
    if (strobe && !strobe_q) begin
      power_q <= power;
    end
  end
endmodule

// ===== verif/fiber_laser_gate_sequencer_monitor.sv
`timescale 1ns/1ns
module fiber_laser_gate_sequencer_monitor (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic [7:0] gen_out,
  input wire logic [7:0] ext_out,
  input wire logic       scan_card_beam_on_out,
  input wire logic       scan_card_modulation_out,
  input wire logic [7:0] scan_card_power_bits
);
  logic       en;
  logic       gt;
  logic       mod_q;
  logic [9:0] run_q;
  assign en = ext_out[5] | gen_out[1];
  assign gt = scan_card_beam_on_out;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mod_q <= 1'b0;
      run_q <= 10'h000;
    end else begin
      mod_q <= scan_card_modulation_out;
      run_q <= (mod_q != scan_card_modulation_out) ? 10'h000 : run_q + 10'h001;
    end
  end
  sequence post_end_s;
    ##[0:23] (!en || gt);
  endsequence
  sequence word_held_s;
    $stable(scan_card_power_bits) ##1 $stable(scan_card_power_bits);
  endsequence
  gate_inverted_a: assert property (gen_out[2] == !gt)
    else $error("inverted gate bit wrong");
  gate_bit_a: assert property (ext_out[5] |-> gen_out[0] == gt)
    else $error("gate bit wrong");
  pre_first_a: assert property ($rose(gt) |-> $past(en))
    else $error("gate opened before enable");
  gate_enabled_a: assert property (gt |-> en)
    else $error("gate open without enable");
  post_bound_a: assert property ($fell(gt) |-> post_end_s)
    else $error("enable held too long");
  cycle_lock_a: assert property ($fell(en) |=> !en [*8])
    else $error("enable back too soon");
  word_stable_a: assert property (ext_out[4] |-> word_held_s)
    else $error("power word moved near strobe");
  strobe_pulse_a: assert property ($rose(ext_out[4]) |=> !ext_out[4])
    else $error("strobe longer than one cycle");
  mod_running_a: assert property (run_q < 10'h12c)
    else $error("modulation stalled");
endmodule
bind fiber_laser_gate_sequencer fiber_laser_gate_sequencer_monitor u_mon (
  .clk_sys(clk_sys), .rst(rst), .gen_out(gen_out), .ext_out(ext_out),
  .scan_card_beam_on_out(scan_card_beam_on_out), .scan_card_modulation_out(scan_card_modulation_out),
  .scan_card_power_bits(scan_card_power_bits));

// ===== verif/fiber_laser_gate_sequencer_bench.sv
`timescale 1ns/1ns
`include "laser_seq_params.svh"
module fiber_laser_gate_sequencer_bench;
  logic        clk_sys, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        scan_card_beam_on_out, scan_card_modulation_out, en, scan_m;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb, sig;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [7:0]  gen_out, ext_out, scan_card_power_bits, power_q;
  int          n_errors, n_compared, n_fall, c, cyc, t0;
  fiber_laser_gate_sequencer uut (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .gen_out, .ext_out,
    .scan_card_beam_on_out, .scan_card_modulation_out, .scan_card_power_bits);
  laser_port_model far (.clk_sys, .strobe(ext_out[4]), .power(scan_card_power_bits), .power_q);
  assign en = ext_out[5] | gen_out[1];
  assign sig = {scan_card_modulation_out, scan_m ? gen_out[0] : ext_out[4], scan_card_beam_on_out, en};
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) cyc <= cyc + 1;
  always @(negedge ext_out[5]) n_fall++;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge clk_sys);
      if (s_axi_awready) begin
        ta = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready) begin
        tw = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk_sys); while (!s_axi_bvalid);
    rsp = s_axi_bresp;
  endtask
  task automatic rd_reg(input logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask
  task automatic wait_for(input int i, input logic v);
    c = 0;
    while (sig[i] !== v) begin
      @(posedge clk_sys);
      c++;
    end
  endtask
  task automatic half(input logic [31:0] f);
    wr(`REG_FREQ, f);
    repeat (3) wait_for(3, !sig[3]);
  endtask
  task automatic close_out;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #3_000_000;
    n_errors++;
    close_out;
  end
  initial begin
    rst = 1'b1;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_araddr, s_axi_arvalid} = '0;
    s_axi_wstrb = 4'hf;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    scan_m = 1'b0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    chk(gen_out, 8'h04);
    rd_reg(`REG_CTRL);
    chk(rd, `CTRL_RESET);
    rd_reg(12'h01c);
    chk(rsp, 2'h2);
    wr(12'h01c, 32'h0000_0000);
    chk(rsp, 2'h2);
    wr(`REG_PRE, 32'h0000_0004);
    chk(rsp, 2'h0);
    wr(`REG_POST, 32'h0000_0014);
    wr(`REG_CYCLE, 32'h0000_000a);
    n_fall = 0;
    wr(`REG_CTRL, 32'h0000_0003);
    wait_for(0, 1'b1);
    wait_for(1, 1'b1);
    chk(32'(c >= 3 && c <= 6), 1);
    chk({gen_out, ext_out}, 16'h0120);
    wr(`REG_CTRL, 32'h0000_0002);
    wr(`REG_CTRL, 32'h0000_0003);
    wait_for(1, 1'b1);
    chk(n_fall, 0);
    wr(`REG_CTRL, 32'h0000_0002);
    wait_for(1, 1'b0);
    wait_for(0, 1'b0);
    chk(32'(c >= 17 && c <= 21), 1);
    t0 = cyc;
    wr(`REG_CTRL, 32'h0000_0003);
    wait_for(0, 1'b1);
    chk(32'(cyc - t0 >= 10), 1);
    wr(`REG_POWER, 32'h0000_00a5);
    wait_for(2, 1'b1);
    chk(scan_card_power_bits, 8'ha5);
    @(posedge clk_sys);
    chk(power_q, 8'ha5);
    wr(`REG_CTRL, 32'h0000_0007);
    scan_m = 1'b1;
    chk({gen_out[2:1], ext_out}, 10'h100);
    wr(`REG_POWER, 32'h0000_003c);
    wait_for(2, 1'b1);
    chk({scan_card_power_bits, ext_out}, 16'h3c00);
    wr(`REG_CTRL, 32'h0000_0002);
    scan_m = 1'b0;
    half(32'h0000_03e8);
    chk(32'(c >= 249 && c <= 251), 1);
    half(32'h0003_0d40);
    chk(32'(c >= 61 && c <= 64), 1);
    wr(`REG_CTRL, 32'h0000_0000);
    half(32'h0001_86a0);
    chk(32'(c >= 49 && c <= 51), 1);
    close_out;
  end
endmodule
